// File: core/vdc_pkg.sv
// Package of constants and types for the discharge and charge rationing control
package vdc_pkg;

  // ***************************************************************
  // Rationing action encodings
  // ***************************************************************
  typedef enum logic [1:0] {
    VDC_ACT_REPORT     = 2'h0,
    VDC_ACT_REPORT_DIS = 2'h1,
    VDC_ACT_DIS_SLEEP  = 2'h2,
    VDC_ACT_IGNORE     = 2'h3
  } vdc_action_type;

  localparam vdc_action_type VDC_ACTION_RST = VDC_ACT_REPORT_DIS;

  // ***************************************************************
  // Register map (word index on the plain port)
  // ***************************************************************
  localparam logic [3:0] VDC_REG_CTRL   = 4'h0;
  localparam logic [3:0] VDC_REG_LIMIT  = 4'h1;
  localparam logic [3:0] VDC_REG_ACCUM  = 4'h2;
  localparam logic [3:0] VDC_REG_STATUS = 4'h3;

  // CTRL fields
  localparam int VDC_CTRL_EN_BIT   = 0;
  localparam int VDC_CTRL_CLR_BIT  = 1;
  localparam int VDC_CTRL_DIS_BIT  = 2;
  localparam int VDC_CTRL_ACT_LSB  = 4;
  // STATUS fields
  localparam int VDC_ST_HIT_BIT    = 0;
  localparam int VDC_ST_DERR_BIT   = 1;
  localparam int VDC_ST_ERR_BIT    = 2;
  localparam int VDC_ST_DIS_BIT    = 3;
  localparam int VDC_ST_SLEEP_BIT  = 4;

  localparam logic [15:0] VDC_LIMIT_RST = 16'hFFFF;

  // ***************************************************************
  // Timing
  // ***************************************************************
  localparam int VDC_CLK_MHZ         = 100;
  localparam int VDC_DISCHARGE_US    = 200;
  localparam int VDC_DISCHARGE_CYC   = VDC_DISCHARGE_US * VDC_CLK_MHZ;
  // One mAh unit of charge = 3600 mA*s; sample per ms so 3600000 mA*ms
  localparam int VDC_MS_CYC          = 1000 * VDC_CLK_MHZ;
  localparam int VDC_MAH_MA_MS       = 3600000;

  // ***************************************************************
  // Discharge sequencer states (Gray along IDLE, RUN, CHECK, ERROR)
  // ***************************************************************
  typedef enum logic [1:0] {
    VDC_DS_IDLE  = 2'b00,
    VDC_DS_RUN   = 2'b01,
    VDC_DS_CHECK = 2'b11,
    VDC_DS_ERROR = 2'b10
  } vdc_dstate_type;

endpackage : vdc_pkg

// File: core/vdc_discharge.sv
// Discharge window timer with end-of-window check
`timescale 1ns/10ps
`default_nettype none
module vdc_discharge
  import vdc_pkg::*;
#(
  parameter int WINDOW_CYC = VDC_DISCHARGE_CYC
) (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic start,
  input  wire logic error_clear,
  input  wire logic vbus_below_check,
  output logic      active,
  output logic      fail_pulse,
  output logic      in_error
);

  initial begin
    if (WINDOW_CYC < 1) $error("vdc_discharge: window must be at least one cycle");
  end

  localparam int CW = $clog2(WINDOW_CYC + 1);

  vdc_dstate_type state_q;
  vdc_dstate_type state_d;
  logic [CW-1:0]  cnt_q;
  logic [CW-1:0]  cnt_d;
  wire            window_done = (cnt_q == CW'(WINDOW_CYC - 1));

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    case (state_q)
      VDC_DS_IDLE: begin
        cnt_d = '0;
        if (start) state_d = VDC_DS_RUN;
      end
      VDC_DS_RUN: begin
        cnt_d = cnt_q + CW'(1);
        if (window_done) state_d = VDC_DS_CHECK;
      end
      VDC_DS_CHECK: begin
        state_d = vbus_below_check ? VDC_DS_IDLE : VDC_DS_ERROR;
      end
      VDC_DS_ERROR: begin
        if (error_clear) state_d = VDC_DS_RUN;
        cnt_d = '0;
      end
      default: state_d = VDC_DS_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      state_q <= VDC_DS_IDLE;
      cnt_q   <= '0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  assign active     = (state_q == VDC_DS_RUN);
  assign fail_pulse = (state_q == VDC_DS_CHECK) && !vbus_below_check;
  assign in_error   = (state_q == VDC_DS_ERROR);

  property p_fail_to_error;
    @(posedge sys_clk) disable iff (srst)
      (state_q == VDC_DS_CHECK && !vbus_below_check) |=> in_error;
  endproperty
  a_fail_to_error: assert property (p_fail_to_error) else $error("failed check not in error");

  property p_pass_to_idle;
    @(posedge sys_clk) disable iff (srst)
      (state_q == VDC_DS_CHECK && vbus_below_check) |=> !in_error && !active;
  endproperty
  a_pass_to_idle: assert property (p_pass_to_idle) else $error("passed check left busy");

endmodule : vdc_discharge
`default_nettype wire

// File: core/vdc_accum.sv
// Charge integrator in mAh with limit compare
`timescale 1ns/10ps
`default_nettype none
module vdc_accum
  import vdc_pkg::*;
#(
  parameter int W       = 16,
  parameter int MS_CYC  = VDC_MS_CYC
) (
  input  wire logic         sys_clk,
  input  wire logic         srst,
  input  wire logic         run,
  input  wire logic         clear,
  input  wire logic [15:0]  bus_current_ma,
  input  wire logic [W-1:0] limit,
  output logic [W-1:0]      charge,
  output logic              reached
);

  initial begin
    if (W < 1 || MS_CYC < 1) $error("vdc_accum: bad parameters");
  end

  localparam int TW = $clog2(MS_CYC + 1);

  logic [TW-1:0] tick_q;
  logic [31:0]   frac_q;
  logic [W-1:0]  charge_q;
  wire           tick      = (tick_q == TW'(MS_CYC - 1));
  wire  [31:0]   frac_sum  = frac_q + {16'h0000, bus_current_ma};
  wire           carry     = (frac_sum >= 32'(VDC_MAH_MA_MS));
  wire  [W-1:0]  charge_nx = (charge_q == {W{1'b1}}) ? charge_q : charge_q + W'(1);

  always_ff @(posedge sys_clk) begin
    if (srst || clear) begin
      tick_q   <= '0;
      frac_q   <= '0;
      charge_q <= '0;
    end else if (run) begin
      tick_q <= tick ? '0 : tick_q + TW'(1);
      if (tick) begin
        frac_q   <= carry ? frac_sum - 32'(VDC_MAH_MA_MS) : frac_sum;
        charge_q <= carry ? charge_nx : charge_q;
      end
    end
  end

  assign charge  = charge_q;
  assign reached = (charge_q >= limit);

  property p_hold_when_idle;
    @(posedge sys_clk) disable iff (srst)
      (!run && !clear) |=> $stable(charge_q);
  endproperty
  a_hold_when_idle: assert property (p_hold_when_idle) else $error("charge moved outside active");

endmodule : vdc_accum
`default_nettype wire

// File: core/vdc_ctrl.sv
// Top: VBUS discharge sequencing and charge rationing control
//
// Functional notes
// - Discharge starts when port power request falls from enabled to disabled.
// - Discharge on removal event, or supply undervoltage with port switch off.
// - Discharge whenever the mode controls command the Sleep state.
// - Discharge before each emulation profile and on Error recovery.
// - Software discharge command honoured only in Active state.
// - Discharge when switching between bypass and port switch either way.
// - At window end, VBUS not below check level sets failure, enters Error.
// - Charge accumulates against the limit only in Active state.
// - Reaching the limit runs the selected action, never enters Error.
// - Action 00 report, 01 report+disconnect (default), 10 sleep, 11 ignore.
// - Report+disconnect: alert, drop profile, open port switch until reset.
// - Disconnect+sleep: open switch, drop profile, data off, monitors off, Sleep.
// - Threshold behaviour held until rationing reset or disabled.
// - Reset clears charge and flag, releases alert, re-evaluates controls.
// - Re-evaluation restarts emulation only if controls changed and enabled.
// - Removal or attach never clears charge; reattach restarts emulation.
// - Action field changes never touch charge; applied at threshold.
// - After threshold a new action applies at once.
// - Sleep to report+disconnect: alert, controls state, both switches open.
// - Disabling before threshold disables rationing and clears charge.
// - Disabling after threshold clears flag, releases alert, re-evaluates.
// - Clear control zeroes charge; after threshold does full reset.
//
// Implementation choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
`default_nettype none
module vdc_ctrl
  import vdc_pkg::*;
#(
  parameter int W          = 16,
  parameter int WINDOW_CYC = VDC_DISCHARGE_CYC,
  parameter int MS_CYC     = VDC_MS_CYC
) (
  input  wire logic        sys_clk,
  input  wire logic        srst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Controls
  input  wire logic        port_power_request,
  input  wire logic        emulation_enable_ctl,
  input  wire logic        mode_select_a,
  input  wire logic        mode_select_b,
  input  wire logic        detect_select,
  // Device state inputs
  input  wire logic        state_active,
  input  wire logic        removal_event,
  input  wire logic        supply_undervolt_level,
  input  wire logic        profile_apply_req,
  input  wire logic        error_recover,
  input  wire logic        port_switch_on,
  input  wire logic        bypass_switch_on,
  input  wire logic        vbus_below_check,
  input  wire logic [15:0] bus_current_ma,
  // Outputs
  output logic             discharge_en,
  output logic             error_state,
  output logic             hit_flag_a_alert,
  output logic             port_switch_block,
  output logic             bypass_block,
  output logic             profile_remove,
  output logic             hs_data_switch_off,
  output logic             monitor_stop,
  output logic             sleep_force,
  output logic             emulation_restart
);

  initial begin
    if (W < 1 || W > 16) $error("vdc_ctrl: W must be 1..16");
  end

  // ***************************************************************
  // Register file
  // ***************************************************************
  logic           hit_flag_a_enable_ctl_q;
  vdc_action_type hit_flag_a_action_sel_q;
  logic [W-1:0]   limit_q;
  logic           hit_flag_a_q;
  logic           disch_fail_q;
  logic [31:0]    rdata_q;

  wire wr_ctrl   = reg_wr && (reg_addr == VDC_REG_CTRL);
  wire wr_limit  = reg_wr && (reg_addr == VDC_REG_LIMIT);
  wire wr_status = reg_wr && (reg_addr == VDC_REG_STATUS);
  wire hit_flag_a_clear_ctl = wr_ctrl && reg_wdata[VDC_CTRL_CLR_BIT];
  wire sw_discharge     = wr_ctrl && reg_wdata[VDC_CTRL_DIS_BIT];
  wire en_falls = wr_ctrl && !reg_wdata[VDC_CTRL_EN_BIT] && hit_flag_a_enable_ctl_q;
  wire [1:0] act_wr = reg_wdata[VDC_CTRL_ACT_LSB +: 2];

  // ***************************************************************
  // Event edges
  // ***************************************************************
  logic ppr_q;
  logic port_sw_q;
  logic byp_sw_q;
  logic byp_seen_q;
  logic port_seen_q;
  logic [4:0] ctl_snap_q;

  wire [4:0] ctl_now = {detect_select, mode_select_a, mode_select_b, emulation_enable_ctl,
                        port_power_request};
  wire sleep_cmd  = !emulation_enable_ctl && !mode_select_a && !mode_select_b;
  logic sleep_cmd_q;

  wire ev_ppr   = ppr_q && !port_power_request;
  wire ev_uvlo  = supply_undervolt_level && !port_switch_on;
  wire ev_sleep = sleep_cmd && !sleep_cmd_q;
  wire ev_sw    = sw_discharge && state_active;
  wire ev_p_on  = port_switch_on && !port_sw_q && byp_seen_q;
  wire ev_b_on  = bypass_switch_on && !byp_sw_q && port_seen_q;

  // ***************************************************************
  // Rationing state
  // ***************************************************************
  logic [W-1:0] charge;
  logic         reached;
  logic         hit_now;
  wire          run_acc = hit_flag_a_enable_ctl_q && state_active && !hit_flag_a_q;
  wire          acc_clr = hit_flag_a_clear_ctl || en_falls;
  wire          release_all = hit_flag_a_q && acc_clr;
  assign hit_now = run_acc && reached && !acc_clr;

  vdc_accum #(
    .W      (W),
    .MS_CYC (MS_CYC)
  ) u_accum (
    .sys_clk        (sys_clk),
    .srst           (srst),
    .run            (run_acc),
    .clear          (acc_clr),
    .bus_current_ma (bus_current_ma),
    .limit          (limit_q),
    .charge         (charge),
    .reached        (reached)
  );

  wire disch_start = ev_ppr || removal_event || ev_uvlo || ev_sleep
                   || profile_apply_req || ev_sw || ev_p_on || ev_b_on;
  logic disch_active;
  logic disch_fail;
  logic disch_err;

  vdc_discharge #(
    .WINDOW_CYC (WINDOW_CYC)
  ) u_disch (
    .sys_clk          (sys_clk),
    .srst             (srst),
    .start            (disch_start),
    .error_clear      (error_recover),
    .vbus_below_check (vbus_below_check),
    .active           (disch_active),
    .fail_pulse       (disch_fail),
    .in_error         (disch_err)
  );

  // Action decode of the held behaviour once threshold reached
  function automatic logic [3:0] act_decode(input vdc_action_type a);
    // {alert, block_switch, remove_profile, sleep}
    case (a)
      VDC_ACT_REPORT:     act_decode = 4'h8;
      VDC_ACT_REPORT_DIS: act_decode = 4'hE;
      VDC_ACT_DIS_SLEEP:  act_decode = 4'h7;
      default:            act_decode = 4'h0;
    endcase
  endfunction

  wire [3:0] eff    = hit_flag_a_q ? act_decode(hit_flag_a_action_sel_q) : 4'h0;
  wire [3:0] eff_nw = act_decode(vdc_action_type'(act_wr));
  wire       act_chg = wr_ctrl && (act_wr != hit_flag_a_action_sel_q) && hit_flag_a_q;
  // Re-evaluation on leaving a disconnecting behaviour
  wire       reeval = (release_all && (eff[2] || eff[0]))
                    || (act_chg && (eff[2] || eff[0]) && !eff_nw[0]);
  wire       restart = reeval && (ctl_now != ctl_snap_q) && emulation_enable_ctl;

  // ***************************************************************
  // Registers
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      hit_flag_a_enable_ctl_q <= 1'b0;
      hit_flag_a_action_sel_q <= VDC_ACTION_RST;
      limit_q             <= W'(VDC_LIMIT_RST);
    end else if (wr_ctrl) begin
      hit_flag_a_enable_ctl_q <= reg_wdata[VDC_CTRL_EN_BIT];
      hit_flag_a_action_sel_q <= vdc_action_type'(act_wr);
    end else if (wr_limit) begin
      limit_q <= reg_wdata[W-1:0];
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst || release_all) begin
      hit_flag_a_q <= 1'b0;
    end else if (hit_now) begin
      hit_flag_a_q <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      disch_fail_q <= 1'b0;
    end else if (disch_fail) begin
      disch_fail_q <= 1'b1;
    end else if (wr_status && reg_wdata[VDC_ST_DERR_BIT]) begin
      disch_fail_q <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      ppr_q       <= 1'b0;
      port_sw_q   <= 1'b0;
      byp_sw_q    <= 1'b0;
      byp_seen_q  <= 1'b0;
      port_seen_q <= 1'b0;
      sleep_cmd_q <= 1'b0;
      ctl_snap_q  <= '0;
    end else begin
      ppr_q       <= port_power_request;
      port_sw_q   <= port_switch_on;
      byp_sw_q    <= bypass_switch_on;
      byp_seen_q  <= bypass_switch_on ? 1'b1 : (port_switch_on ? 1'b0 : byp_seen_q);
      port_seen_q <= port_switch_on ? 1'b1 : (bypass_switch_on ? 1'b0 : port_seen_q);
      sleep_cmd_q <= sleep_cmd;
      if (hit_now) ctl_snap_q <= ctl_now;
    end
  end

  // ***************************************************************
  // Output flops
  // ***************************************************************
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      discharge_en       <= 1'b0;
      error_state        <= 1'b0;
      hit_flag_a_alert       <= 1'b0;
      port_switch_block  <= 1'b0;
      bypass_block       <= 1'b0;
      profile_remove     <= 1'b0;
      hs_data_switch_off <= 1'b0;
      monitor_stop       <= 1'b0;
      sleep_force        <= 1'b0;
      emulation_restart  <= 1'b0;
    end else begin
      discharge_en       <= disch_active || (disch_start && !discharge_en && !disch_err)
                         || (error_recover && disch_err);
      error_state        <= disch_err || disch_fail;
      hit_flag_a_alert       <= eff[3];
      port_switch_block  <= eff[2] || eff[0];
      bypass_block       <= eff[2];
      profile_remove     <= eff[1];
      hs_data_switch_off <= eff[0];
      monitor_stop       <= eff[0];
      sleep_force        <= eff[0];
      emulation_restart  <= restart || (removal_event && !hit_flag_a_q);
    end
  end

  // ***************************************************************
  // Read port
  // ***************************************************************
  wire [31:0] rd_mux =
      (reg_addr == VDC_REG_CTRL)   ? {26'h0, hit_flag_a_action_sel_q, 3'h0, hit_flag_a_enable_ctl_q} :
      (reg_addr == VDC_REG_LIMIT)  ? 32'(limit_q) :
      (reg_addr == VDC_REG_ACCUM)  ? 32'(charge) :
      (reg_addr == VDC_REG_STATUS) ? {27'h0, sleep_force, discharge_en, error_state,
                                      disch_fail_q, hit_flag_a_q} : 32'h0000_0000;

  always_ff @(posedge sys_clk) begin
    if (srst) rdata_q <= '0;
    else      rdata_q <= reg_rd ? rd_mux : 32'h0000_0000;
  end
  assign reg_rdata = rdata_q;

  // ***************************************************************
  // Checks
  // ***************************************************************
  property p_ppr_disch;
    @(posedge sys_clk) disable iff (srst)
      (ev_ppr && !disch_err && !discharge_en) |=> discharge_en ##1 discharge_en;
  endproperty
  a_ppr_disch: assert property (p_ppr_disch) else $error("no discharge on power drop");

  property p_sw_gated;
    @(posedge sys_clk) disable iff (srst)
      (sw_discharge && !state_active && !disch_start && !disch_active && !disch_err)
        |=> !discharge_en;
  endproperty
  a_sw_gated: assert property (p_sw_gated) else $error("discharge outside active");

  property p_default_action;
    @(posedge sys_clk) $rose(srst) ##1 srst |-> hit_flag_a_action_sel_q == VDC_ACT_REPORT_DIS;
  endproperty
  a_default_action: assert property (p_default_action) else $error("bad reset action");

  property p_disconnect_eff;
    @(posedge sys_clk) disable iff (srst)
      (hit_flag_a_q && hit_flag_a_action_sel_q == VDC_ACT_REPORT_DIS && !wr_ctrl && !acc_clr)
        |=> hit_flag_a_alert && port_switch_block && profile_remove && !sleep_force;
  endproperty
  a_disconnect_eff: assert property (p_disconnect_eff) else $error("report-disconnect wrong");

  property p_sleep_eff;
    @(posedge sys_clk) disable iff (srst)
      (hit_flag_a_q && hit_flag_a_action_sel_q == VDC_ACT_DIS_SLEEP && !wr_ctrl && !acc_clr)
        |=> sleep_force && hs_data_switch_off && monitor_stop && !hit_flag_a_alert;
  endproperty
  a_sleep_eff: assert property (p_sleep_eff) else $error("disconnect-sleep wrong");

  property p_reset_release;
    @(posedge sys_clk) disable iff (srst)
      release_all |=> !hit_flag_a_q ##1 !hit_flag_a_alert && !port_switch_block;
  endproperty
  a_reset_release: assert property (p_reset_release) else $error("reset did not release");

  property p_no_error_on_hit;
    @(posedge sys_clk) disable iff (srst)
      (hit_now && !disch_err && !disch_fail) |=> !error_state;
  endproperty
  a_no_error_on_hit: assert property (p_no_error_on_hit) else $error("hit caused error");

  property p_clear_zero;
    @(posedge sys_clk) disable iff (srst)
      acc_clr |=> charge == '0;
  endproperty
  a_clear_zero: assert property (p_clear_zero) else $error("clear left charge");

endmodule : vdc_ctrl
`default_nettype wire

// File: verif/vdc_vbus_model.sv
// Behavioural model of the VBUS line seen by the discharge check
`timescale 1ns/10ps
`default_nettype none
module vdc_vbus_model (
  input  wire logic sys_clk,
  input  wire logic srst,
  input  wire logic discharge_en,
  input  wire logic port_switch_on,
  input  wire logic stuck,
  output logic      vbus_below_check
);
  logic [3:0] cnt_q;
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      cnt_q <= 4'h0;
      vbus_below_check <= 1'b0;
    end else begin
      cnt_q <= discharge_en ? cnt_q + 4'h1 : 4'h0;
      // VBUS sinks a few cycles into a window unless held up
      if (discharge_en) vbus_below_check <= ~stuck & (cnt_q > 4'h3);
      else if (port_switch_on) vbus_below_check <= 1'b0;
    end
  end
endmodule : vdc_vbus_model
`default_nettype wire

// File: verif/vdc_ctrl_test.sv
// Register level test of the discharge and rationing control
`timescale 1ns/10ps
`default_nettype none
module vdc_ctrl_test;
  import vdc_pkg::*;
  localparam int WIN = 10;
  logic sys_clk, srst, reg_wr, reg_rd, port_power_request, emulation_enable_ctl, stuck;
  logic mode_select_a, mode_select_b, detect_select, state_active, removal_event;
  logic supply_undervolt_level, profile_apply_req, error_recover, port_switch_on;
  logic bypass_switch_on, vbus_below_check, discharge_en, error_state, hit_flag_a_alert;
  logic port_switch_block, bypass_block, profile_remove, hs_data_switch_off;
  logic monitor_stop, sleep_force, emulation_restart;
  logic [3:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, v;
  logic [15:0] bus_current_ma;
  logic [3:0]  ra [5] = '{VDC_REG_CTRL, VDC_REG_LIMIT, VDC_REG_ACCUM, VDC_REG_STATUS, 4'hF};
  logic [31:0] re [5] = '{32'h10, 32'hFFFF, 32'h0, 32'h0, 32'h0};
  int fails, checked, cyc, hi, run_len, rs;
  vdc_ctrl #(.WINDOW_CYC(WIN), .MS_CYC(4)) i_vdc_ctrl (.sys_clk, .srst, .reg_addr,
    .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .port_power_request, .emulation_enable_ctl,
    .mode_select_a, .mode_select_b, .detect_select, .state_active, .removal_event,
    .supply_undervolt_level, .profile_apply_req, .error_recover, .port_switch_on,
    .bypass_switch_on, .vbus_below_check, .bus_current_ma, .discharge_en, .error_state,
    .hit_flag_a_alert, .port_switch_block, .bypass_block, .profile_remove, .hs_data_switch_off,
    .monitor_stop, .sleep_force, .emulation_restart);
  vdc_vbus_model i_vdc_vbus_model (.sys_clk, .srst, .discharge_en, .port_switch_on, .stuck,
    .vbus_below_check);
  // ***************************************************************
  // Clock, timeout and tasks
  // ***************************************************************
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (emulation_restart === 1'b1) rs++;
    if (discharge_en === 1'b1) hi++;
    else if (hi != 0) begin
      run_len = hi;
      hi = 0;
    end
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task summarize();
    if (fails == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] g, input logic [31:0] e);
    checked++;
    if (g !== e) begin
      fails++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1;
  endtask : wr
  task rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask : rd
  task p(input int k);
    @(posedge sys_clk);
    case (k)
      0: removal_event <= 1'b1;
      1: profile_apply_req <= 1'b1;
      default: error_recover <= 1'b1;
    endcase
    @(posedge sys_clk);
    {removal_event, profile_apply_req, error_recover} <= 3'h0;
  endtask : p
  task dis(input logic f);
    int n;
    n = 0;
    while (discharge_en !== 1'b1 && n < 5) begin
      @(posedge sys_clk);
      #1 n++;
    end
    chk(discharge_en, 1);
    n = 0;
    while (discharge_en === 1'b1 && n < 40) begin
      @(posedge sys_clk);
      #1 n++;
    end
    repeat (3) @(posedge sys_clk);
    #1 chk(run_len, WIN + 1);
    chk(error_state, f);
  endtask : dis
  task wa();
    int n;
    n = 0;
    while (hit_flag_a_alert !== 1'b1 && n < 800) begin
      @(posedge sys_clk);
      #1 n++;
    end
  endtask : wa
  // ***************************************************************
  // Test sequence
  // ***************************************************************
  initial begin
    {reg_wr, reg_rd, port_power_request, mode_select_a, mode_select_b, stuck} = 6'h0;
    {state_active, removal_event, supply_undervolt_level, profile_apply_req} = 4'h0;
    {error_recover, port_switch_on, bypass_switch_on} = 3'h0;
    {emulation_enable_ctl, detect_select, srst} = 3'h7;
    reg_addr = 4'h0;
    reg_wdata = 32'h0;
    bus_current_ma = 16'hEA60;
    repeat (4) @(posedge sys_clk);
    srst <= 1'b0;
    for (int i = 0; i < 5; i++) begin
      rd(ra[i], v);
      chk(v, re[i]);
    end
    port_power_request <= 1'b1;
    repeat (3) @(posedge sys_clk);
    port_power_request <= 1'b0;
    dis(0);
    p(0);
    dis(0);
    supply_undervolt_level <= 1'b1;
    @(posedge sys_clk) supply_undervolt_level <= 1'b0;
    dis(0);
    emulation_enable_ctl <= 1'b0;
    @(posedge sys_clk) emulation_enable_ctl <= 1'b1;
    dis(0);
    p(1);
    dis(0);
    wr(VDC_REG_CTRL, 32'h14);
    repeat (10) @(posedge sys_clk);
    #1 chk(discharge_en, 0);
    state_active <= 1'b1;
    wr(VDC_REG_CTRL, 32'h14);
    dis(0);
    bypass_switch_on <= 1'b1;
    repeat (30) @(posedge sys_clk);
    {bypass_switch_on, port_switch_on} <= 2'b01;
    dis(0);
    {bypass_switch_on, port_switch_on} <= 2'b10;
    dis(0);
    stuck <= 1'b1;
    p(0);
    dis(1);
    rd(VDC_REG_STATUS, v);
    chk(v[2:1], 2'h3);
    chk(rs, 2);
    stuck <= 1'b0;
    p(2);
    dis(0);
    state_active <= 1'b0;
    wr(VDC_REG_LIMIT, 32'h3);
    wr(VDC_REG_CTRL, 32'h11);
    repeat (300) @(posedge sys_clk);
    rd(VDC_REG_ACCUM, v);
    chk(v, 0);
    state_active <= 1'b1;
    repeat (300) @(posedge sys_clk);
    rd(VDC_REG_ACCUM, v);
    chk(v, 1);
    wr(VDC_REG_CTRL, 32'h10);
    rd(VDC_REG_ACCUM, v);
    chk(v, 0);
    wr(VDC_REG_LIMIT, 32'h1);
    wr(VDC_REG_CTRL, 32'h11);
    wa();
    chk({hit_flag_a_alert, port_switch_block, profile_remove, error_state}, 4'hE);
    wr(VDC_REG_CTRL, 32'h21);
    chk({hit_flag_a_alert, sleep_force, hs_data_switch_off, monitor_stop}, 4'h7);
    mode_select_a <= 1'b1;
    wr(VDC_REG_CTRL, 32'h11);
    chk({hit_flag_a_alert, port_switch_block, bypass_block, sleep_force}, 4'hE);
    chk(rs, 3);
    wr(VDC_REG_CTRL, 32'h13);
    chk({hit_flag_a_alert, port_switch_block, profile_remove}, 3'h0);
    rd(VDC_REG_ACCUM, v);
    chk(v, 0);
    chk(rs, 4);
    wr(VDC_REG_CTRL, 32'h01);
    wa();
    chk({hit_flag_a_alert, port_switch_block}, 2'h2);
    wr(VDC_REG_CTRL, 32'h00);
    chk(hit_flag_a_alert, 0);
    wr(VDC_REG_CTRL, 32'h31);
    repeat (400) @(posedge sys_clk);
    rd(VDC_REG_STATUS, v);
    chk({v[0], hit_flag_a_alert, port_switch_block}, 3'h4);
    summarize();
  end
endmodule : vdc_ctrl_test
`default_nettype wire
